// ==== rtl/dwc_ctrl.sv ====
// host controller driving a 64K x 1 multiplexed-address dram
// assumes dout pin is asynchronous; one request port, self-timed refresh
//
// Contract
// - early write lowers write enable before the column strobe.
// - read-modify-write lowers write enable late, after access.
// - write data valid before column strobe, held past hold time.
// - random write cycles spaced at least the cycle time.
// - strobes meet minimum widths, never beyond the maximum width.
// - row strobe high for precharge before any new cycle.
// - write enable held low past both strobe hold times.
// - write enable leads both strobe rises; pulse long enough.
// - read-modify-write cycle, row and column widths honoured.
// - page column cycles spaced; column precharge between them.
// - page read-modify-write column cycle meets its minimum.
// - ordinary page mode caps row strobe low time.
// - extended page option allows longer row strobe low time.
// - column-to-row gap met since column rises before row falls.
// - read keeps write enable high; write takes it low.
// - page mode keeps row low across column cycles.
// - all 128 low row addresses refreshed each 2 ms.
`timescale 1ns/1ps
module dwc_ctrl #(
  parameter bit EXT_PAGE = 1'b0,
  parameter int REF_INTERVAL = dwc_pkg::C_REF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // request port
  input wire logic req_valid,
  input wire dwc_pkg::dwc_req_type req,
  output logic req_ready,
  output logic rd_valid,
  output logic rd_data,
  // dram pins
  output dwc_pkg::dwc_pins_type pins,
  input wire logic dram_dout
);
  typedef struct packed {
    dwc_pkg::dwc_st_type st;
    logic [dwc_pkg::CW-1:0] t;
    logic [dwc_pkg::CW-1:0] rt;
    logic [dwc_pkg::CW-1:0] ref_t;
    logic [6:0] ref_row;
    logic ref_due;
    dwc_pkg::dwc_req_type cur;
    logic [7:0] row;
    logic pg;
    logic pend;
    logic rdy;
    logic rv;
    logic rd;
    logic [1:0] dsync;
    dwc_pkg::dwc_pins_type p;
  } dwc_state_type;
  dwc_state_type s_ff, nxt_s;
  logic [dwc_pkg::CW-1:0] ras_lim;
  logic [dwc_pkg::CW-1:0] col_need;
  logic [dwc_pkg::CW-1:0] cas_need;
  logic fits;
  function automatic logic [dwc_pkg::CW-1:0] cnt(input int v);
    return v[dwc_pkg::CW-1:0];
  endfunction
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    ras_lim = EXT_PAGE ? cnt(dwc_pkg::C_RPM2) : cnt(dwc_pkg::C_RAS_MAX);
    cas_need = (s_ff.cur.op == dwc_pkg::OP_RMW) ? cnt(dwc_pkg::C_CRW)
                                                : cnt(dwc_pkg::C_CAS);
    col_need = (s_ff.cur.op == dwc_pkg::OP_RMW) ? cnt(dwc_pkg::C_PCM)
                                                : cnt(dwc_pkg::C_PC);
    fits = (s_ff.rt + cnt(dwc_pkg::C_PCM)) < ras_lim;
    nxt_s.dsync = {s_ff.dsync[0], dram_dout};
    nxt_s.t = s_ff.t + 1'b1;
    nxt_s.rv = 1'b0;
    nxt_s.rdy = 1'b0;
    if (s_ff.p.ras_n == 1'b0) begin
      nxt_s.rt = s_ff.rt + 1'b1;
    end else begin
      nxt_s.rt = '0;
    end
    if (s_ff.ref_t >= cnt(REF_INTERVAL - 1)) begin
      nxt_s.ref_t = '0;
      nxt_s.ref_due = 1'b1;
    end else begin
      nxt_s.ref_t = s_ff.ref_t + 1'b1;
    end
    unique case (s_ff.st)
      dwc_pkg::ST_IDLE: begin
        // ready already stood at this edge, so the request outranks refresh
        if (s_ff.rdy && req_valid) begin
          nxt_s.cur = req;
          nxt_s.row = req.addr[15:8];
          nxt_s.p.a = req.addr[15:8];
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_ROW;
        end else if (s_ff.ref_due) begin
          // a wrap in this same cycle keeps the flag up
          nxt_s.ref_due = (s_ff.ref_t >= cnt(REF_INTERVAL - 1));
          nxt_s.p.a = {1'b0, s_ff.ref_row};
          nxt_s.ref_row = s_ff.ref_row + 1'b1;
          nxt_s.p.ras_n = 1'b0;
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_REF;
        end else begin
          nxt_s.rdy = 1'b1;
        end
      end
      dwc_pkg::ST_ROW: begin
        // address settles a cycle before the row strobe falls
        nxt_s.p.ras_n = 1'b0;
        nxt_s.t = '0;
        nxt_s.st = dwc_pkg::ST_COL;
      end
      dwc_pkg::ST_COL: begin
        if (s_ff.t == cnt(dwc_pkg::C_RAH)) begin
          nxt_s.p.a = s_ff.cur.addr[7:0];
          nxt_s.p.din = s_ff.cur.wdata;
          if (s_ff.cur.op == dwc_pkg::OP_WRITE) begin
            nxt_s.p.we_n = 1'b0;
          end
        end
        if (s_ff.t >= cnt(dwc_pkg::C_RCD) && s_ff.t > cnt(dwc_pkg::C_RAH)) begin
          nxt_s.p.cas_n = 1'b0;
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_CASH;
        end
      end
      dwc_pkg::ST_CASH: begin
        // late write enable only after both access delays: rmw
        if (s_ff.cur.op == dwc_pkg::OP_RMW && s_ff.p.we_n &&
            s_ff.t >= cnt(dwc_pkg::C_CWD) &&
            s_ff.rt >= cnt(dwc_pkg::C_RWD)) begin
          nxt_s.p.we_n = 1'b0;
        end
        // raise cas only with enough write lead and width
        if (s_ff.t >= cas_need && s_ff.rt >= cnt(dwc_pkg::C_RRW) &&
            (s_ff.cur.op != dwc_pkg::OP_RMW || (!s_ff.p.we_n &&
             s_ff.t >= cnt(dwc_pkg::C_CWD) + cnt(dwc_pkg::C_RWL) + 1'b1))) begin
          // sampled as cas rises: both access times have long run out
          if (s_ff.cur.op != dwc_pkg::OP_WRITE) begin
            nxt_s.rd = s_ff.dsync[1];
            nxt_s.rv = 1'b1;
          end
          nxt_s.p.cas_n = 1'b1;
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_OPEN;
        end
      end
      dwc_pkg::ST_OPEN: begin
        nxt_s.p.we_n = 1'b1;
        if (s_ff.t == '0) begin
          // no page offer while refresh waits, or pages could starve it
          nxt_s.rdy = s_ff.cur.page && !s_ff.ref_due;
        end
        // an offer met with ready is always taken; another row waits
        if (s_ff.rdy && req_valid) begin
          nxt_s.cur = req;
          nxt_s.pg = (req.addr[15:8] == s_ff.row);
          nxt_s.pend = (req.addr[15:8] != s_ff.row);
        end
        // page column: precharge then next cas, held to column cycle time
        if (s_ff.pg && fits && s_ff.t >= cnt(dwc_pkg::C_CP) &&
            s_ff.t + cas_need >= col_need) begin
          nxt_s.pg = 1'b0;
          nxt_s.p.a = s_ff.cur.addr[7:0];
          nxt_s.p.din = s_ff.cur.wdata;
          nxt_s.p.we_n = (s_ff.cur.op == dwc_pkg::OP_WRITE) ? 1'b0 : 1'b1;
          nxt_s.t = cnt(dwc_pkg::C_RAH);
          nxt_s.st = dwc_pkg::ST_COL;
        end else if (s_ff.t >= cnt(dwc_pkg::C_CP) &&
                     ((s_ff.pg && !fits) ||
                      (!s_ff.pg && (!s_ff.cur.page || s_ff.pend ||
                       s_ff.rt >= ras_lim - cnt(dwc_pkg::C_RRW) ||
                       s_ff.ref_due)))) begin
          // a column that no longer fits reopens the row after precharge
          nxt_s.pend = s_ff.pend || s_ff.pg;
          nxt_s.pg = 1'b0;
          nxt_s.p.ras_n = 1'b1;
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_PRE;
        end
      end
      dwc_pkg::ST_PRE: begin
        if (s_ff.t >= cnt(dwc_pkg::C_RC - dwc_pkg::C_RAS)
            && s_ff.t >= cnt(dwc_pkg::C_RWC - dwc_pkg::C_RRW)
            && s_ff.t >= cnt(dwc_pkg::C_RP)) begin
          if (s_ff.pend) begin
            nxt_s.pend = 1'b0;
            nxt_s.row = s_ff.cur.addr[15:8];
            nxt_s.p.a = s_ff.cur.addr[15:8];
            nxt_s.t = '0;
            nxt_s.st = dwc_pkg::ST_ROW;
          end else begin
            nxt_s.st = dwc_pkg::ST_IDLE;
          end
        end
      end
      dwc_pkg::ST_REF: begin
        if (s_ff.t >= cnt(dwc_pkg::C_RAS)) begin
          nxt_s.p.ras_n = 1'b1;
          nxt_s.t = '0;
          nxt_s.st = dwc_pkg::ST_PRE;
        end
      end
      default: begin
        nxt_s.st = dwc_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.p <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, a: 8'h00, din: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign pins = s_ff.p;
  assign req_ready = s_ff.rdy;
  assign rd_valid = s_ff.rv;
  assign rd_data = s_ff.rd;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ras_width;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(s_ff.p.ras_n) |-> !s_ff.p.ras_n [*8];
  endproperty
  a_ras_width: assert property (p_ras_width) else $error("ras short");
  property p_cas_width;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(s_ff.p.cas_n) |-> !s_ff.p.cas_n [*8];
  endproperty
  a_cas_width: assert property (p_cas_width) else $error("cas short");
  property p_precharge;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(s_ff.p.ras_n) |-> s_ff.p.ras_n [*8];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge");
  property p_cas_pre;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(s_ff.p.cas_n) |-> s_ff.p.cas_n [*3];
  endproperty
  a_cas_pre: assert property (p_cas_pre) else $error("cas pre");
  property p_we_lead;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(s_ff.p.cas_n) |-> !$past(s_ff.p.we_n, 5) || $past(s_ff.p.we_n);
  endproperty
  a_we_lead: assert property (p_we_lead) else $error("we lead");
  property p_cas_in_ras;
    @(posedge sys_clk) disable iff (sys_rst)
      !s_ff.p.cas_n |-> !s_ff.p.ras_n;
  endproperty
  a_cas_in_ras: assert property (p_cas_in_ras) else $error("cas alone");
  property p_ras_max;
    @(posedge sys_clk) disable iff (sys_rst)
      s_ff.rt <= ras_lim;
  endproperty
  a_ras_max: assert property (p_ras_max) else $error("ras long");
  property p_early;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(s_ff.p.cas_n) && s_ff.cur.op == dwc_pkg::OP_WRITE
        |-> !s_ff.p.we_n;
  endproperty
  a_early: assert property (p_early) else $error("late write");
  c_write: cover property (@(posedge sys_clk) $fell(s_ff.p.we_n));
  c_refresh: cover property (@(posedge sys_clk) s_ff.st == dwc_pkg::ST_REF);
  c_page: cover property (@(posedge sys_clk) s_ff.pg);
endmodule // dwc_ctrl

// ==== rtl/dwc_pkg.sv ====
// constants and carrier types for the dram write/page cycle controller
// assumes a 125 MHz sys_clk; all timings in ns, all but T_WCR_NS converted to cycles here
package dwc_pkg;
  localparam int CLK_NS = 8;
  // ----------------------------------------
  // timing figures (faster grade), ns
  // ----------------------------------------
  localparam int T_RC_NS = 260;
  localparam int T_RAS_MIN_NS = 150;
  localparam int T_CAS_MIN_NS = 85;
  localparam int T_RP_NS = 100;
  localparam int T_WCR_NS = 95;
  localparam int T_RWL_NS = 40;
  localparam int T_DH_NS = 30;
  localparam int T_RWC_NS = 280;
  localparam int T_RRW_NS = 170;
  localparam int T_CRW_NS = 105;
  localparam int T_RWD_NS = 125;
  localparam int T_CWD_NS = 60;
  localparam int T_PC_NS = 125;
  localparam int T_PCM_NS = 145;
  localparam int T_CP_NS = 30;
  localparam int T_RCD_NS = 30;
  localparam int T_RAH_NS = 20;
  localparam int T_RAS_MAX_NS = 10000;
  localparam int T_RPM2_NS = 75000;
  localparam int T_REF_NS = 2000000;
  localparam int REF_ROWS = 128;
  // ----------------------------------------
  // cycle counts: minima round up, maxima round down
  // ----------------------------------------
  function automatic int up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  function automatic int dn(input int ns);
    return ns / CLK_NS;
  endfunction
  localparam int C_RAS = up(T_RAS_MIN_NS);
  localparam int C_CAS = up(T_CAS_MIN_NS);
  localparam int C_RP = up(T_RP_NS);
  localparam int C_RC = up(T_RC_NS);
  localparam int C_RWC = up(T_RWC_NS);
  localparam int C_RRW = up(T_RRW_NS);
  localparam int C_CRW = up(T_CRW_NS);
  localparam int C_RWD = up(T_RWD_NS);
  localparam int C_CWD = up(T_CWD_NS);
  localparam int C_RWL = up(T_RWL_NS);
  localparam int C_PC = up(T_PC_NS);
  localparam int C_PCM = up(T_PCM_NS);
  localparam int C_CP = up(T_CP_NS);
  localparam int C_RCD = up(T_RCD_NS);
  localparam int C_RAH = up(T_RAH_NS);
  localparam int C_DH = up(T_DH_NS);
  localparam int C_RAS_MAX = dn(T_RAS_MAX_NS);
  localparam int C_RPM2 = dn(T_RPM2_NS);
  localparam int C_REF = dn(T_REF_NS) / REF_ROWS;
  localparam int CW = 16;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_RMW = 2'b10
  } dwc_op_type;
  typedef struct packed {
    dwc_op_type op;
    logic [15:0] addr;
    logic wdata;
    logic page;
  } dwc_req_type;
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [7:0] a;
    logic din;
  } dwc_pins_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW = 3'b001,
    ST_COL = 3'b010,
    ST_CASH = 3'b011,
    ST_OPEN = 3'b100,
    ST_PRE = 3'b101,
    ST_REF = 3'b110
  } dwc_st_type;
endpackage

// ==== sim/dwc_dram_model.sv ====
// partner model: 64K x 1 dram cell array seen through the pin struct
// assumes pins change just after sys_clk rises; dout not pulled
`timescale 1ns/1ps
module dwc_dram_model (
  // clock
  input wire logic sys_clk,
  // dram pins
  input wire dwc_pkg::dwc_pins_type pins,
  output logic dram_dout
);
  logic mem [0:65535];
  logic [7:0] row;
  logic [15:0] ca;
  logic rq = 1'b1;
  logic cq = 1'b1;
  logic wq = 1'b1;
  logic early = 1'b1;
  logic rdv = 1'b0;
  initial dram_dout = 1'b0;
  // ----------------------------------------
  // strobe edges
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rq && !pins.ras_n) row = pins.a;
    if (cq && !pins.cas_n) begin
      ca = {row, pins.a};
      rdv = mem[ca];
      early = !pins.we_n;
      if (!pins.we_n) mem[ca] = pins.din;
    end else if (!pins.cas_n && wq && !pins.we_n) begin
      mem[ca] = pins.din;
    end
    // released line toggles so a stale bit never reads as data
    if (!pins.cas_n && !early) dram_dout <= rdv;
    else dram_dout <= ~dram_dout;
    rq = pins.ras_n;
    cq = pins.cas_n;
    wq = pins.we_n;
  end
endmodule // dwc_dram_model

// ==== sim/tb_dwc_ctrl.sv ====
// testbench: controller against the dram model, table of accesses
// assumes shortened refresh interval of 200 cycles
`timescale 1ns/1ps
module tb_dwc_ctrl;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  dwc_pkg::dwc_req_type req = '0;
  logic req_ready;
  logic rd_valid;
  logic rd_data;
  dwc_pkg::dwc_pins_type pins;
  logic dram_dout;
  int miscompares = 0;
  int checks = 0;
  int rl = 0;
  int rh = 1000;
  int cl = 0;
  logic rq = 1'b1;
  logic cq = 1'b1;
  logic wq = 1'b1;
  logic [1:0] cur_op = 2'h0;
  logic seen [128];
  // op(2) addr(16) wdata page exp; op 0 read, 1 write, 2 rmw
  logic [20:0] tab [17] = '{
    {2'h1, 16'h1234, 3'b100}, {2'h1, 16'hab00, 3'b000},
    {2'h1, 16'hffff, 3'b100}, {2'h1, 16'h5501, 3'b110},
    {2'h1, 16'h5502, 3'b010}, {2'h0, 16'h1234, 3'b001},
    {2'h0, 16'hab00, 3'b000}, {2'h0, 16'hffff, 3'b001},
    {2'h0, 16'h5501, 3'b011}, {2'h0, 16'h5502, 3'b010},
    {2'h2, 16'h1234, 3'b001}, {2'h2, 16'h5502, 3'b110},
    {2'h0, 16'h1234, 3'b000}, {2'h0, 16'h5502, 3'b001},
    {2'h2, 16'h5501, 3'b011}, {2'h2, 16'h5502, 3'b011},
    {2'h0, 16'h5501, 3'b000}};
  dwc_ctrl #(.EXT_PAGE(1'b0), .REF_INTERVAL(200)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .pins(pins), .dram_dout(dram_dout));
  dwc_dram_model i_mem (.sys_clk(sys_clk), .pins(pins),
    .dram_dout(dram_dout));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic run_row(input logic [20:0] t);
    int n;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= t[20:1];
    n = 0;
    do begin @(negedge sys_clk); n++; end
    while (req_ready !== 1'b1 && n < 500);
    chk(n < 500, 1);
    cur_op = t[20:19];
    @(posedge sys_clk);
    req_valid <= 1'b0;
    if (t[20:19] != 2'h1) begin
      n = 0;
      do begin @(negedge sys_clk); n++; end
      while (rd_valid !== 1'b1 && n < 300);
      chk(n < 300, 1);
      chk(rd_data, t[0]);
    end
  endtask
  // ----------------------------------------
  // pin monitor, sampled where pins are settled
  // ----------------------------------------
  always @(negedge sys_clk) if (!sys_rst) begin
    if (!pins.ras_n && rq) begin
      chk(rh >= dwc_pkg::C_RP, 1);
      seen[pins.a[6:0]] = 1'b1;
    end
    if (pins.ras_n && !rq) begin
      chk(rl >= dwc_pkg::C_RAS, 1);
      chk(rl <= dwc_pkg::C_RAS_MAX, 1);
    end
    if (pins.cas_n && !cq) chk(cl >= dwc_pkg::C_CAS, 1);
    if (!pins.cas_n && cq) chk(pins.we_n, cur_op != 2'h1);
    if (!pins.we_n && wq && cur_op == 2'h2) begin
      chk(cl >= dwc_pkg::C_CWD, 1);
      chk(rl >= dwc_pkg::C_RWD, 1);
    end
    rl = pins.ras_n ? 0 : rl + 1;
    rh = pins.ras_n ? rh + 1 : 0;
    cl = pins.cas_n ? 0 : cl + 1;
    rq = pins.ras_n;
    cq = pins.cas_n;
    wq = pins.we_n;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) seen[i] = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({pins.ras_n, pins.cas_n, pins.we_n, req_ready}, 4'he);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (tab[i]) run_row(tab[i]);
    // idle long enough for the refresh counter to sweep all rows
    repeat (128 * 200 + 400) @(posedge sys_clk);
    for (int i = 0; i < 128; i++) chk(seen[i], 1);
    give_verdict();
  end
  initial begin
    #(8 * 40000);
    miscompares++;
    give_verdict();
  end
endmodule // tb_dwc_ctrl
